// ---- rtl/fos1_pkg.sv ----
package fos1_pkg;
  // Bus shape
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NPIN = 2;
  localparam int unsigned NCMP = 6;
  localparam int unsigned NSEL = 3;

  // Register offsets (word index on the plain port)
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_START = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_CANCEL = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h4;

  // Control register field positions
  localparam int unsigned POS_LVL_LO = 0;
  localparam int unsigned POS_LVL_HI = 1;
  localparam int unsigned POS_SEL_LO = 2;
  localparam int unsigned POS_SEL_HI = 4;
  localparam int unsigned POS_MODE_LO = 5;
  localparam int unsigned POS_MODE_HI = 6;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 8'h7f;

  // Status register field positions
  localparam int unsigned POS_STAT_STOP = 0;
  localparam int unsigned POS_STAT_TRIG = 2;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] TRIG_RST = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

  // Clear-condition modes
  localparam logic [1:0] CLR_NOW = 2'h0;
  localparam logic [1:0] CLR_GATED = 2'h1;
  localparam logic [1:0] CLR_PERIOD = 2'h2;
  localparam logic [1:0] CLR_GATED_PERIOD = 2'h3;

  // Per-pin release state, one-hot
  typedef enum logic [2:0] {
    FOS1_RUN = 3'h1,
    FOS1_STOP = 3'h2,
    FOS1_PEND = 3'h4
  } fos1_state_t;

  // Selected comparator lines for one timer instance
  function automatic logic [NSEL-1:0] fos1_cmp_map(input logic [1:0] inst,
                                                    input logic [NCMP-1:0] cmp);
    logic [NSEL-1:0] m;
    m[0] = cmp[0];
    case (inst)
      2'h0: begin
        m[1] = cmp[1];
        m[2] = cmp[2];
      end
      2'h1: begin
        m[1] = cmp[2];
        m[2] = cmp[3];
      end
      default: begin
        m[1] = cmp[4];
        m[2] = cmp[5];
      end
    endcase
    return m;
  endfunction : fos1_cmp_map
endpackage : fos1_pkg

// ---- rtl/fos1_reg_if.sv ----
`timescale 1ns/1ps
interface fos1_reg_if;
  import fos1_pkg::*;
  logic [DATA_W-1:0] ctrl [NPIN];
  logic [NPIN-1:0] start_pulse;
  logic [NPIN-1:0] cancel_pulse;
  logic [NPIN-1:0] stop_state;
  logic [NPIN-1:0] trig_level;

  modport regs (
    output ctrl,
    output start_pulse,
    output cancel_pulse,
    input stop_state,
    input trig_level
  );
  modport core (
    input ctrl,
    input start_pulse,
    input cancel_pulse,
    output stop_state,
    output trig_level
  );
endinterface : fos1_reg_if

// ---- rtl/fos1_regs.sv ----
`timescale 1ns/1ps
module fos1_regs (
  input wire logic clk, // Timer clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [fos1_pkg::ADDR_W-1:0] addr, // Register index
  input wire logic [fos1_pkg::DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [fos1_pkg::DATA_W-1:0] rdata, // Read data, cycle after rd
  fos1_reg_if.regs bus // Towards the stop logic
);
  import fos1_pkg::*;

  logic [DATA_W-1:0] ctrl_q [NPIN];
  logic [DATA_W-1:0] rdata_q;
  logic wr_start;
  logic wr_cancel;

  // Trigger registers hold no state: a write of 1 is a one-cycle request,
  // so after reset both read as their cleared value [RULE_17]
  assign wr_start = wr && (addr == OFS_START);
  assign wr_cancel = wr && (addr == OFS_CANCEL);
  assign bus.start_pulse = wr_start ? wdata[NPIN-1:0] : TRIG_RST[NPIN-1:0]; // [RULE_07]
  assign bus.cancel_pulse = wr_cancel ? wdata[NPIN-1:0] : TRIG_RST[NPIN-1:0]; // [RULE_16]
  assign bus.ctrl = ctrl_q;

  // Control registers; upper bit is kept clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q[0] <= CTRL_RST;
      ctrl_q[1] <= CTRL_RST;
    end else if (wr && addr == OFS_CTRL0) begin
      ctrl_q[0] <= wdata & CTRL_WMASK;
    end else if (wr && addr == OFS_CTRL1) begin
      ctrl_q[1] <= wdata & CTRL_WMASK;
    end
  end

  // Read port: data stand one cycle, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= RDATA_RST;
    end else if (rd) begin
      case (addr)
        OFS_CTRL0: rdata_q <= ctrl_q[0];
        OFS_CTRL1: rdata_q <= ctrl_q[1];
        OFS_STATUS: begin
          rdata_q <= RDATA_RST;
          rdata_q[POS_STAT_STOP +: NPIN] <= bus.stop_state;
          rdata_q[POS_STAT_TRIG +: NPIN] <= bus.trig_level;
        end
        OFS_START: rdata_q <= TRIG_RST; // [RULE_15]
        default: rdata_q <= RDATA_RST;
      endcase
    end else begin
      rdata_q <= RDATA_RST;
    end
  end

  assign rdata = rdata_q;
endmodule : fos1_regs

// ---- rtl/fos1_top.sv ----
`timescale 1ns/1ps
// How it works
// RULE_01: Trigger forces stop level without CPU help
// RULE_02: Release happens on timer clock edge
// RULE_03: Level field: 0x Hi-Z, 10 low, 11 high
// RULE_04: Select bits map comparators per timer instance
// RULE_05: Stop input ORs enabled comparators and start
// RULE_06: Rising edge of stop input enters stop
// RULE_07: Start bit one acts like trigger edge
// RULE_08: Mode 00: cancel releases immediately, any level
// RULE_09: Mode 01: cancel ignored while trigger active
// RULE_10: Mode 10: cancel releases at next period
// RULE_11: Mode 11: gated cancel, release at period
// RULE_12: Stopped timer holds pending release until restart
// RULE_13: High stop input is active, low inactive
// RULE_14: Software writes zeros to cancel upper bits
// RULE_15: Start trigger register always reads zero
// RULE_16: Cancel bit one requests release per mode
// RULE_17: Reset clears start and cancel triggers
// RULE_18: Each of two pins has own logic
module fos1_top #(
  parameter logic [1:0] TIMER_INST = 2'h0 // Timer instance 0, 1 or 2
) (
  input wire logic clk, // Timer operation clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [fos1_pkg::ADDR_W-1:0] reg_addr, // Register index
  input wire logic [fos1_pkg::DATA_W-1:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [fos1_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [fos1_pkg::NCMP-1:0] cmp_out, // Comparator outputs, high active
  input wire logic [fos1_pkg::NPIN-1:0] timer_out, // Normal timer waveform per pin
  input wire logic timer_run_enable, // Companion timer is counting
  input wire logic period_start, // Pulse at start of a counter period
  output logic [fos1_pkg::NPIN-1:0] timer_output_pin_o, // Pin drive value
  output logic [fos1_pkg::NPIN-1:0] timer_output_pin_oe, // Pin drive enable
  output logic [fos1_pkg::NPIN-1:0] stop_active // Pin in forced stop
);
  import fos1_pkg::*;

  fos1_reg_if rif ();

  fos1_regs u_regs (
    .clk(clk),
    .rst_b(rst_b),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .wr(reg_wr),
    .rd(reg_rd),
    .rdata(reg_rdata),
    .bus(rif.regs)
  );

  fos1_state_t st_q [NPIN];
  fos1_state_t st_d [NPIN];
  logic [NPIN-1:0] stop_in;
  logic [NPIN-1:0] stop_in_q;
  logic [NPIN-1:0] trig_lvl;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] cancel_ok;
  logic [NPIN-1:0] pin_o_q;
  logic [NPIN-1:0] pin_oe_q;
  logic [NPIN-1:0] stop_q;
  logic [NSEL-1:0] cmp_sel;

  // Comparator lines as this timer instance sees them
  assign cmp_sel = fos1_cmp_map(TIMER_INST, cmp_out); // [RULE_04]

  // Trigger combine and edge detect, separately for each pin [RULE_18]
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      trig_lvl[p] = |(cmp_sel & rif.ctrl[p][POS_SEL_HI:POS_SEL_LO]); // [RULE_04]
      stop_in[p] = trig_lvl[p] | rif.start_pulse[p]; // [RULE_05]
      // A start write counts even if a comparator already holds the input high
      rise[p] = (stop_in[p] & ~stop_in_q[p]) | rif.start_pulse[p]; // [RULE_06] [RULE_07]
      // Gated modes refuse the cancel while the input is high [RULE_13]
      cancel_ok[p] = rif.cancel_pulse[p] &
                     (~rif.ctrl[p][POS_MODE_LO] | ~stop_in[p]); // [RULE_09] [RULE_11]
    end
  end

  // Previous stop input level for edge detection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stop_in_q <= '0;
    end else begin
      stop_in_q <= stop_in;
    end
  end

  // Release sequencing; a fresh trigger always beats a cancel or period release
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      st_d[p] = st_q[p];
      case (st_q[p])
        FOS1_RUN: begin
          if (rise[p]) begin
            st_d[p] = FOS1_STOP; // [RULE_01] [RULE_06]
          end
        end
        FOS1_STOP: begin
          if (rise[p]) begin
            st_d[p] = FOS1_STOP;
          end else if (cancel_ok[p]) begin
            // Period modes wait for the counter, direct modes go now
            if (rif.ctrl[p][POS_MODE_HI]) begin
              st_d[p] = FOS1_PEND; // [RULE_10] [RULE_11] [RULE_16]
            end else begin
              st_d[p] = FOS1_RUN; // [RULE_08] [RULE_09] [RULE_16]
            end
          end
        end
        FOS1_PEND: begin
          if (rise[p]) begin
            st_d[p] = FOS1_STOP;
          end else if (period_start && timer_run_enable) begin
            // A halted timer gives no period, so the stop is held [RULE_12]
            st_d[p] = FOS1_RUN; // [RULE_10] [RULE_11]
          end
        end
        default: st_d[p] = FOS1_RUN;
      endcase
    end
  end

  // State register; changes only on the timer clock edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q[0] <= FOS1_RUN;
      st_q[1] <= FOS1_RUN;
    end else begin
      st_q[0] <= st_d[0]; // [RULE_02]
      st_q[1] <= st_d[1]; // [RULE_02]
    end
  end

  // Pin drive follows the next state, so stop and pin move on the same edge;
  // with synchronous inputs this is the quickest a registered pin can react
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_o_q <= '0;
      pin_oe_q <= '0;
      stop_q <= '0;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        stop_q[p] <= (st_d[p] != FOS1_RUN);
        if (st_d[p] == FOS1_RUN) begin
          pin_o_q[p] <= timer_out[p];
          pin_oe_q[p] <= 1'b1;
        end else begin
          // Low level bit 0 only picks the level once the high bit fixes it
          pin_oe_q[p] <= rif.ctrl[p][POS_LVL_HI]; // [RULE_01] [RULE_03]
          pin_o_q[p] <= rif.ctrl[p][POS_LVL_HI] & rif.ctrl[p][POS_LVL_LO]; // [RULE_03]
        end
      end
    end
  end

  // Status seen by software
  assign rif.stop_state = stop_q;
  assign rif.trig_level = trig_lvl;

  assign timer_output_pin_o = pin_o_q;
  assign timer_output_pin_oe = pin_oe_q;
  assign stop_active = stop_q;
endmodule : fos1_top

// ---- tb/fos1_partner.sv ----
`timescale 1ns/1ps
module fos1_partner #(
  parameter int PERIOD = 12 // Counter period in clocks
) (
  input wire logic clk, // Timer clock
  input wire logic rst_b, // Reset, active low
  input wire logic run, // Counter enable
  input wire logic [fos1_pkg::NCMP-1:0] cmp_req, // Levels asked for
  output logic [fos1_pkg::NCMP-1:0] cmp_out, // Comparator outputs
  output logic [fos1_pkg::NPIN-1:0] timer_out, // Normal waveform
  output logic period_start // Period pulse
);
  import fos1_pkg::*;
  int cnt;
  // Comparators settle one clock after the analog level moves
  always_ff @(posedge clk) cmp_out <= rst_b ? cmp_req : '0;
  // Counter holds while run is low, so no period pulse shows when stopped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt <= 0;
      period_start <= 1'b0;
      timer_out <= 2'h1;
    end else if (run) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      period_start <= (cnt == PERIOD - 1);
      if (cnt == PERIOD - 1) timer_out <= ~timer_out;
    end else begin
      period_start <= 1'b0;
    end
  end
endmodule : fos1_partner

// ---- tb/fos1_top_asserts.sv ----
`timescale 1ns/1ps
module fos1_top_chk #(
  parameter logic [1:0] TIMER_INST = 2'h0 // Timer instance
) (
  input wire logic clk, // Timer clock
  input wire logic rst_b, // Reset, active low
  input wire logic [fos1_pkg::ADDR_W-1:0] reg_addr, // Register index
  input wire logic [fos1_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [fos1_pkg::DATA_W-1:0] reg_rdata, // Read data
  input wire logic [fos1_pkg::NCMP-1:0] cmp_out, // Comparators
  input wire logic [fos1_pkg::NPIN-1:0] timer_out, // Normal waveform
  input wire logic timer_run_enable, // Timer counting
  input wire logic period_start, // Period pulse
  input wire logic [fos1_pkg::NPIN-1:0] timer_output_pin_o, // Pin value
  input wire logic [fos1_pkg::NPIN-1:0] timer_output_pin_oe, // Pin enable
  input wire logic [fos1_pkg::NPIN-1:0] stop_active // Forced stop
);
  import fos1_pkg::*;
  logic [DATA_W-1:0] ctrl_q;
  logic [2:0] cmp_m;
  logic sin, sin_q, rise, cancel, pend_q, tout_q;
  // Pin 0 only; pin 1 is the same logic and the bench covers it
  assign cmp_m = {cmp_out[TIMER_INST == 2'h0 ? 2 : TIMER_INST == 2'h1 ? 3 : 5],
    cmp_out[TIMER_INST == 2'h0 ? 1 : TIMER_INST == 2'h1 ? 2 : 4], cmp_out[0]};
  assign sin = |(ctrl_q[4:2] & cmp_m);
  assign rise = (sin && !sin_q) || (reg_wr && reg_addr == OFS_START && reg_wdata[0]);
  assign cancel = reg_wr && reg_addr == OFS_CANCEL && reg_wdata[0];
  // Shadow of the pin 0 control register
  always_ff @(posedge clk) begin
    if (!rst_b) ctrl_q <= CTRL_RST;
    else if (reg_wr && reg_addr == OFS_CTRL0) ctrl_q <= reg_wdata & CTRL_WMASK;
  end
  // A start write is part of the stop input, so it also feeds the edge history
  always_ff @(posedge clk) sin_q <= rst_b && (sin ||
    (reg_wr && reg_addr == OFS_START && reg_wdata[0]));
  always_ff @(posedge clk) tout_q <= timer_out[0];
  // Pending release; a cancel landing on a period edge is left unjudged
  always_ff @(posedge clk) begin
    if (!rst_b || rise || (period_start && timer_run_enable)) pend_q <= 1'b0;
    else if (cancel && ctrl_q[6] && stop_active[0] && !(ctrl_q[5] && sin)) pend_q <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_cancel_now;
    cancel && ctrl_q[6:5] == CLR_NOW && !rise;
  endsequence
  sequence s_pend_go;
    pend_q && period_start && timer_run_enable && !rise;
  endsequence
  start_reads_zero_a: assert property (reg_rd && reg_addr == OFS_START |=> reg_rdata == 8'h00)
    else $error("start register read not zero");
  rise_stops_a: assert property (rise |=> stop_active[0])
    else $error("stop not entered on rising edge");
  stop_level_a: assert property (stop_active[0] |-> timer_output_pin_oe[0] == ctrl_q[1]
    && timer_output_pin_o[0] == &ctrl_q[1:0]) else $error("wrong stop drive");
  release_normal_a: assert property ($fell(stop_active[0]) |-> timer_output_pin_oe[0]
    && timer_output_pin_o[0] == tout_q) else $error("release not back to timer output");
  now_cancel_a: assert property (s_cancel_now |=> !stop_active[0])
    else $error("immediate cancel did not release");
  gated_ignore_a: assert property (cancel && ctrl_q[6:5] == CLR_GATED && sin
    && stop_active[0] |=> stop_active[0]) else $error("cancel taken while trigger active");
  gated_release_a: assert property (cancel && ctrl_q[6:5] == CLR_GATED && !sin && !rise
    |=> !stop_active[0]) else $error("gated cancel did not release");
  period_wait_a: assert property (cancel && ctrl_q[6] && stop_active[0] && !rise
    && !(period_start && timer_run_enable) |=> stop_active[0]) else $error("released before period");
  pend_release_a: assert property (s_pend_go |=> !stop_active[0])
    else $error("pending release missed period");
  norun_hold_a: assert property (pend_q && !timer_run_enable |=> stop_active[0])
    else $error("released while timer stopped");
endmodule : fos1_top_chk
bind fos1_top fos1_top_chk #(.TIMER_INST(TIMER_INST)) u_chk (.clk, .rst_b, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_out, .timer_out, .timer_run_enable,
  .period_start, .timer_output_pin_o, .timer_output_pin_oe, .stop_active);

// ---- tb/test_fos1_top.sv ----
`timescale 1ns/1ps
module test_fos1_top;
  import fos1_pkg::*;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, run = 1, per;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wd = '0, rdat;
  logic [NCMP-1:0] creq = '0, cmp;
  logic [NPIN-1:0] tout, tq, po, poe, stp;
  int errors = 0, n_compared = 0;
  // Clock and the timer value the design registered at each edge
  always #50 clk = ~clk;
  always @(posedge clk) tq <= tout;
  fos1_partner #(.PERIOD(12)) u_far (.clk, .rst_b, .run, .cmp_req(creq), .cmp_out(cmp),
    .timer_out(tout), .period_start(per));
  fos1_top #(.TIMER_INST(2'h2)) uut (.clk, .rst_b, .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .cmp_out(cmp), .timer_out(tout),
    .timer_run_enable(run), .period_start(per), .timer_output_pin_o(po),
    .timer_output_pin_oe(poe), .stop_active(stp));
  task automatic test_done;
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  // Pin state as {stop, enable, value}; Hi-Z drives value low
  task automatic chk_pin(input int p, input logic st, input logic [1:0] lvl);
    logic [2:0] exp;
    exp = st ? {1'b1, lvl[1], &lvl} : {2'h1, tq[p]};
    chk_reg({5'h00, stp[p], poe[p], po[p]}, {5'h00, exp});
  endtask : chk_pin
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk_reg(rdat, e);
  endtask : rd_chk
  // Comparator moves, partner adds a clock, design registers the result
  task automatic cmp_set(input logic [NCMP-1:0] v);
    @(posedge clk);
    creq <= v;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : cmp_set
  // Bounded wait until just after the edge that carries a period pulse
  task automatic wait_per;
    int k;
    k = 0;
    @(negedge clk);
    while (per !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > 40) begin
        errors++;
        test_done;
      end
    end
    @(negedge clk);
  endtask : wait_per
  initial begin
    logic [2:0] sel;
    logic [1:0] lvl;
    logic [NCMP-1:0] c;
    void'($urandom(67203));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) rd_chk(a[2:0], 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        lvl = 2'($urandom);
        sel = 3'($urandom_range(7, 1));
        c = sel[0] ? 6'h01 : sel[1] ? 6'h10 : 6'h20;
        wr_reg(3'(p), {1'b0, 2'(m), sel, lvl});
        cmp_set(c);
        chk_pin(p, 1'b1, lvl);
        chk_pin(1 - p, 1'b0, 2'h0);
        rd_chk(OFS_STATUS, 8'h05 << p);
        if (m[1]) wait_per;
        wr_reg(OFS_CANCEL, 8'(1 << p));
        @(negedge clk);
        chk_pin(p, m != 0, lvl);
        if (m == 2) begin
          @(posedge clk);
          run <= 1'b0;
          repeat (30) @(posedge clk);
          @(negedge clk);
          chk_pin(p, 1'b1, lvl);
          @(posedge clk);
          run <= 1'b1;
          wait_per;
          chk_pin(p, 1'b0, lvl);
        end
        cmp_set('0);
        if (m[0]) begin
          if (m[1]) wait_per;
          wr_reg(OFS_CANCEL, 8'(1 << p));
          @(negedge clk);
          chk_pin(p, m[1], lvl);
          if (m[1]) wait_per;
        end
        chk_pin(p, 1'b0, lvl);
        wr_reg(3'(p), 8'h00);
      end
    end
    wr_reg(OFS_CTRL0, 8'h03);
    wr_reg(OFS_START, 8'h00);
    @(negedge clk);
    chk_pin(0, 1'b0, 2'h3);
    wr_reg(OFS_START, 8'h01);
    @(negedge clk);
    chk_pin(0, 1'b1, 2'h3);
    rd_chk(OFS_START, 8'h00);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // Last reset edge leaves the pin undriven; the next edge hands it to the timer
    @(negedge clk);
    chk_reg({5'h00, stp[0], poe[0], po[0]}, 8'h00);
    @(negedge clk);
    chk_pin(0, 1'b0, 2'h0);
    rd_chk(OFS_CTRL0, 8'h00);
    test_done;
  end
endmodule : test_fos1_top
